/* File: rtl/conv_clock_select_regs.vh */
// register map, field positions and timing constants of the conversion sequencer
`ifndef CONV_CLOCK_SELECT_REGS_VH
`define CONV_CLOCK_SELECT_REGS_VH

// ****************************************************************
// register indexes (byte address is four times the index)
// ****************************************************************
`define CONV_CLOCK_SELECT_IDX_CORE_IRQ 8'h0B
`define CONV_CLOCK_SELECT_IDX_IRQ_FLAGS 8'h0C
`define CONV_CLOCK_SELECT_IDX_RES_HIGH 8'h1E
`define CONV_CLOCK_SELECT_IDX_CTRL 8'h1F
`define CONV_CLOCK_SELECT_IDX_IRQ_EN 8'h8C
`define CONV_CLOCK_SELECT_IDX_PIN_SEL 8'h91
`define CONV_CLOCK_SELECT_IDX_RES_LOW 8'h9E
`define CONV_CLOCK_SELECT_IDX_CLK_SEL 8'h9F
`define CONV_CLOCK_SELECT_ADDR_W 10

// ****************************************************************
// reset values
// ****************************************************************
`define CONV_CLOCK_SELECT_RST_CORE_IRQ 8'h00
`define CONV_CLOCK_SELECT_RST_IRQ_FLAGS 8'h00
`define CONV_CLOCK_SELECT_RST_CTRL 8'h00
`define CONV_CLOCK_SELECT_RST_IRQ_EN 8'h00
`define CONV_CLOCK_SELECT_RST_PIN_SEL 8'hFF
`define CONV_CLOCK_SELECT_RST_CLK_SEL 8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define CONV_CLOCK_SELECT_CTRL_POWER 0
`define CONV_CLOCK_SELECT_CTRL_GO 1
`define CONV_CLOCK_SELECT_CTRL_CHAN_LO 2
`define CONV_CLOCK_SELECT_CTRL_CHAN_HI 4
`define CONV_CLOCK_SELECT_CTRL_POS_REF 5
`define CONV_CLOCK_SELECT_CTRL_NEG_REF 6
`define CONV_CLOCK_SELECT_CTRL_JUSTIFY 7
`define CONV_CLOCK_SELECT_CLK_SEL_LO 4
`define CONV_CLOCK_SELECT_CLK_SEL_HI 6
`define CONV_CLOCK_SELECT_CLK_SEL_MASK 8'h70
`define CONV_CLOCK_SELECT_DONE_BIT 6
`define CONV_CLOCK_SELECT_GLOBAL_EN_BIT 7
`define CONV_CLOCK_SELECT_PERIPH_GATE_BIT 6

// ****************************************************************
// conversion clock dividers and conversion length
// ****************************************************************
`define CONV_CLOCK_SELECT_DIV_2 6'h01
`define CONV_CLOCK_SELECT_DIV_4 6'h03
`define CONV_CLOCK_SELECT_DIV_8 6'h07
`define CONV_CLOCK_SELECT_DIV_16 6'h0F
`define CONV_CLOCK_SELECT_DIV_32 6'h1F
`define CONV_CLOCK_SELECT_DIV_64 6'h3F
`define CONV_CLOCK_SELECT_RC_CODE 2'h3
`define CONV_CLOCK_SELECT_RES_BITS 10
`define CONV_CLOCK_SELECT_TOP_BIT 4'h9
`define CONV_CLOCK_SELECT_TRIAL_START 10'h200
`define CONV_CLOCK_SELECT_MSB_HI 9
`define CONV_CLOCK_SELECT_MSB_LO 8

`endif

/* File: rtl/conv_clock_select_tad_gen.v */
// conversion bit period tick generator
`timescale 1ns/1ps
`default_nettype none
`include "conv_clock_select_regs.vh"

module conv_clock_select_tad_gen
(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire run,
  input wire [2:0] clk_sel,
  input wire rc_tick,
  output reg tad_tick
);

  reg [5:0] cnt_reg;
  reg [5:0] div_last;

  // terminal count from the clock select field
  always @*
  begin
    case (clk_sel)
      3'h0: div_last = `CONV_CLOCK_SELECT_DIV_2;
      3'h1: div_last = `CONV_CLOCK_SELECT_DIV_8;
      3'h2: div_last = `CONV_CLOCK_SELECT_DIV_32;
      3'h4: div_last = `CONV_CLOCK_SELECT_DIV_4;
      3'h5: div_last = `CONV_CLOCK_SELECT_DIV_16;
      3'h6: div_last = `CONV_CLOCK_SELECT_DIV_64;
      default: div_last = `CONV_CLOCK_SELECT_DIV_2;
    endcase
  end

  // divider; the rc source uses the oscillator tick directly
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 6'h00;
      tad_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        cnt_reg <= 6'h00;
        tad_tick <= 1'b0;
      end
      else if (clk_sel[1:0] == `CONV_CLOCK_SELECT_RC_CODE)
      begin
        cnt_reg <= 6'h00;
        tad_tick <= rc_tick;
      end
      else if (cnt_reg == div_last)
      begin
        cnt_reg <= 6'h00;
        tad_tick <= 1'b1;
      end
      else
      begin
        cnt_reg <= cnt_reg + 6'h01;
        tad_tick <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/conv_clock_select_sequencer.v */
// conversion sequencer: apb registers, sar control, sleep and reset behaviour
//
// Contract
// - writing the start bit requests conversion
// - completion clears start bit, loads results
// - done flag set by hardware, software clears
// - one bit per selected bit period
// - result has ten bits
// - rc clock delays start one instruction
// - enabled completion during sleep wakes core
// - wake branches to vector if global enable
// - disabled completion in sleep powers converter down
// - sleep aborts non-rc conversion, power bit kept
// - reset clears control, keeps result registers
// - justify bit selects result alignment
// - clock select decode with rc code
// - power bit runs or shuts converter
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "conv_clock_select_regs.vh"

module conv_clock_select_sequencer
(
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`CONV_CLOCK_SELECT_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sleep_mode,
  input wire instr_tick,
  input wire rc_tick,
  input wire comp_high,
  output reg [`CONV_CLOCK_SELECT_RES_BITS-1:0] sar_trial,
  output reg sample_en,
  output reg converter_live,
  output reg [2:0] channel_sel,
  output reg pos_reference_select,
  output reg neg_reference_select,
  output reg [7:0] analog_pin_mask,
  output reg irq_request,
  output reg wake_pulse,
  output reg vector_branch
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT_INSTR = 3'h1;
  localparam ST_SETUP = 3'h2;
  localparam ST_BITS = 3'h3;
  localparam ST_FINISH = 3'h4;

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [7:0] core_irq_control_reg;
  reg [7:0] irq_flags_reg;
  reg [7:0] irq_enables_reg;
  reg [7:0] pin_select_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] clk_sel_reg;
  reg [7:0] result_high_reg;
  reg [7:0] result_low_reg;
  reg [2:0] state_reg;
  reg [3:0] bit_idx_reg;
  reg powered_down_reg;
  reg [31:0] rd_mux;
  reg mapped;

  wire [7:0] index = paddr[`CONV_CLOCK_SELECT_ADDR_W-1:2];
  wire word_ok = (paddr[1:0] == 2'h0);
  wire setup_ph = psel && !penable;
  wire wr_commit = psel && penable && pready && pwrite && !pslverr;
  wire [2:0] conv_clk_sel = clk_sel_reg[`CONV_CLOCK_SELECT_CLK_SEL_HI:`CONV_CLOCK_SELECT_CLK_SEL_LO];
  wire rc_selected = (conv_clk_sel[1:0] == `CONV_CLOCK_SELECT_RC_CODE);
  wire power_on = ctrl_reg[`CONV_CLOCK_SELECT_CTRL_POWER];
  wire done_ie = irq_enables_reg[`CONV_CLOCK_SELECT_DONE_BIT];
  wire busy = (state_reg != ST_IDLE);
  wire run_tad = (state_reg == ST_SETUP) || (state_reg == ST_BITS);
  wire tad_tick;

  // ****************************************************************
  // write strobes and conversion events
  // ****************************************************************
  wire wr_ctrl = wr_commit && (index == `CONV_CLOCK_SELECT_IDX_CTRL);
  wire wr_flags = wr_commit && (index == `CONV_CLOCK_SELECT_IDX_IRQ_FLAGS);
  wire start_req = wr_ctrl && pwdata[`CONV_CLOCK_SELECT_CTRL_GO] && pwdata[`CONV_CLOCK_SELECT_CTRL_POWER];
  wire abort_sw = wr_ctrl && !pwdata[`CONV_CLOCK_SELECT_CTRL_GO];
  // power bit as this cycle's write leaves it, so power-on plus start is not lost
  wire power_next = wr_ctrl ? pwdata[`CONV_CLOCK_SELECT_CTRL_POWER] : power_on;
  wire sleep_abort = sleep_mode && !rc_selected && busy;
  wire last_bit = (state_reg == ST_BITS) && tad_tick && (bit_idx_reg == 4'h0);
  wire conv_done = (state_reg == ST_FINISH);

  // ****************************************************************
  // bit period generator
  // ****************************************************************
  conv_clock_select_tad_gen u_tad
  (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .run(run_tad),
    .clk_sel(conv_clk_sel),
    .rc_tick(rc_tick),
    .tad_tick(tad_tick)
  );

  // ****************************************************************
  // read data decode
  // ****************************************************************
  always @*
  begin
    rd_mux = 32'h0000_0000;
    mapped = word_ok;
    case (index)
      `CONV_CLOCK_SELECT_IDX_CORE_IRQ: rd_mux[7:0] = core_irq_control_reg;
      `CONV_CLOCK_SELECT_IDX_IRQ_FLAGS: rd_mux[7:0] = irq_flags_reg;
      `CONV_CLOCK_SELECT_IDX_RES_HIGH: rd_mux[7:0] = result_high_reg;
      `CONV_CLOCK_SELECT_IDX_CTRL: rd_mux[7:0] = ctrl_reg;
      `CONV_CLOCK_SELECT_IDX_IRQ_EN: rd_mux[7:0] = irq_enables_reg;
      `CONV_CLOCK_SELECT_IDX_PIN_SEL: rd_mux[7:0] = pin_select_reg;
      `CONV_CLOCK_SELECT_IDX_RES_LOW: rd_mux[7:0] = result_low_reg;
      `CONV_CLOCK_SELECT_IDX_CLK_SEL: rd_mux[7:0] = clk_sel_reg;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************************************
  // apb answer: no wait states, registered outputs
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      if (setup_ph)
      begin
        pready <= 1'b1;
        pslverr <= !mapped;
        prdata <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_irq_control_reg <= `CONV_CLOCK_SELECT_RST_CORE_IRQ;
      irq_enables_reg <= `CONV_CLOCK_SELECT_RST_IRQ_EN;
      pin_select_reg <= `CONV_CLOCK_SELECT_RST_PIN_SEL;
      clk_sel_reg <= `CONV_CLOCK_SELECT_RST_CLK_SEL;
    end
    else if (clk_en && wr_commit)
    begin
      case (index)
        `CONV_CLOCK_SELECT_IDX_CORE_IRQ: core_irq_control_reg <= pwdata[7:0];
        `CONV_CLOCK_SELECT_IDX_IRQ_EN: irq_enables_reg <= pwdata[7:0];
        `CONV_CLOCK_SELECT_IDX_PIN_SEL: pin_select_reg <= pwdata[7:0];
        `CONV_CLOCK_SELECT_IDX_CLK_SEL: clk_sel_reg <= pwdata[7:0] & `CONV_CLOCK_SELECT_CLK_SEL_MASK;
        default: core_irq_control_reg <= core_irq_control_reg;
      endcase
    end
  end

  // ****************************************************************
  // flag register: hardware set beats software clear
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_flags_reg <= `CONV_CLOCK_SELECT_RST_IRQ_FLAGS;
    else if (clk_en)
    begin
      if (wr_flags)
        irq_flags_reg <= pwdata[7:0];
      if (conv_done)
        irq_flags_reg[`CONV_CLOCK_SELECT_DONE_BIT] <= 1'b1;
    end
  end

  // ****************************************************************
  // control register: start bit cleared by hardware on finish
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= `CONV_CLOCK_SELECT_RST_CTRL;
    else if (clk_en)
    begin
      if (wr_ctrl)
      begin
        ctrl_reg <= pwdata[7:0];
        ctrl_reg[`CONV_CLOCK_SELECT_CTRL_GO] <= start_req;
      end
      if (conv_done || sleep_abort)
        ctrl_reg[`CONV_CLOCK_SELECT_CTRL_GO] <= 1'b0;
    end
  end

  // ****************************************************************
  // conversion state machine and successive approximation
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      bit_idx_reg <= 4'h0;
      sar_trial <= {`CONV_CLOCK_SELECT_RES_BITS{1'b0}};
    end
    else if (clk_en)
    begin
      if (sleep_abort || abort_sw || !power_next)
        state_reg <= ST_IDLE;
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (start_req)
              state_reg <= rc_selected ? ST_WAIT_INSTR : ST_SETUP;
          end
          ST_WAIT_INSTR:
          begin
            if (instr_tick)
              state_reg <= ST_SETUP;
          end
          ST_SETUP:
          begin
            if (tad_tick)
            begin
              state_reg <= ST_BITS;
              bit_idx_reg <= `CONV_CLOCK_SELECT_TOP_BIT;
              sar_trial <= `CONV_CLOCK_SELECT_TRIAL_START;
            end
          end
          ST_BITS:
          begin
            if (tad_tick)
            begin
              // keep or drop the bit under test, then try the next one
              sar_trial[bit_idx_reg] <= comp_high;
              if (bit_idx_reg != 4'h0)
                sar_trial[bit_idx_reg - 4'h1] <= 1'b1;
              bit_idx_reg <= bit_idx_reg - 4'h1;
              if (last_bit)
                state_reg <= ST_FINISH;
            end
          end
          ST_FINISH:
            state_reg <= ST_IDLE;
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // result registers: no reset, they survive device reset
  // ****************************************************************
  always @(posedge pclk)
  begin
    if (clk_en && conv_done)
    begin
      if (ctrl_reg[`CONV_CLOCK_SELECT_CTRL_JUSTIFY])
      begin
        result_high_reg <= {6'h00, sar_trial[`CONV_CLOCK_SELECT_MSB_HI:`CONV_CLOCK_SELECT_MSB_LO]};
        result_low_reg <= sar_trial[7:0];
      end
      else
      begin
        result_high_reg <= sar_trial[`CONV_CLOCK_SELECT_MSB_HI:2];
        result_low_reg <= {sar_trial[1:0], 6'h00};
      end
    end
  end

  // ****************************************************************
  // sleep power down and wake signalling
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      powered_down_reg <= 1'b0;
      wake_pulse <= 1'b0;
      vector_branch <= 1'b0;
    end
    else if (clk_en)
    begin
      wake_pulse <= conv_done && sleep_mode && done_ie;
      if (conv_done && sleep_mode && done_ie)
        vector_branch <= core_irq_control_reg[`CONV_CLOCK_SELECT_GLOBAL_EN_BIT];
      if (!sleep_mode)
        powered_down_reg <= 1'b0;
      else if ((conv_done && !done_ie) || sleep_abort)
        powered_down_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // registered analog side outputs and interrupt request
  // ****************************************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_live <= 1'b0;
      sample_en <= 1'b0;
      channel_sel <= 3'h0;
      pos_reference_select <= 1'b0;
      neg_reference_select <= 1'b0;
      analog_pin_mask <= `CONV_CLOCK_SELECT_RST_PIN_SEL;
      irq_request <= 1'b0;
    end
    else if (clk_en)
    begin
      converter_live <= power_on && !powered_down_reg;
      sample_en <= power_on && !powered_down_reg && !run_tad;
      channel_sel <= ctrl_reg[`CONV_CLOCK_SELECT_CTRL_CHAN_HI:`CONV_CLOCK_SELECT_CTRL_CHAN_LO];
      pos_reference_select <= ctrl_reg[`CONV_CLOCK_SELECT_CTRL_POS_REF];
      neg_reference_select <= ctrl_reg[`CONV_CLOCK_SELECT_CTRL_NEG_REF];
      analog_pin_mask <= pin_select_reg;
      irq_request <= irq_flags_reg[`CONV_CLOCK_SELECT_DONE_BIT] && done_ie
        && core_irq_control_reg[`CONV_CLOCK_SELECT_PERIPH_GATE_BIT];
    end
  end

endmodule
`default_nettype wire

/* File: tb/conv_clock_select_seq_assertions.sv */
// port-level assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module conv_clock_select_seq_checker
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_mode,
  input wire logic sample_en,
  input wire logic converter_live,
  input wire logic [7:0] analog_pin_mask,
  input wire logic irq_request,
  input wire logic wake_pulse,
  input wire logic vector_branch
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // bus timing, reset state, sleep and wake
  // ****************************************************************
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_one_ready;
    pready ##1 !pready;
  endsequence
  AST_READY_AFTER_SETUP: assert property (s_setup |=> s_one_ready)
    else $error("no single pready after setup");
  AST_ERR_READS_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without pready or with data");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  AST_RESET_STATE: assert property ($rose(presetn) |->
    analog_pin_mask == 8'hFF && !converter_live && !sample_en && !irq_request)
    else $error("outputs not at reset state");
  AST_WAKE_IN_SLEEP: assert property (wake_pulse |-> $past(sleep_mode) ##1 !wake_pulse)
    else $error("wake outside sleep or longer than one cycle");
  AST_VECTOR_AT_WAKE: assert property ($changed(vector_branch) |->
    wake_pulse || $past(wake_pulse))
    else $error("vector flag changed without wake");
  AST_POWER_GATES_SAMPLE: assert property (!converter_live |-> !sample_en)
    else $error("sampling while converter off");
  AST_SLEEP_KEEPS_OFF: assert property (!converter_live && sleep_mode |=> !converter_live)
    else $error("converter back on during sleep");
endmodule

bind conv_clock_select_sequencer conv_clock_select_seq_checker u_chk
(
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .sleep_mode(sleep_mode),
  .sample_en(sample_en),
  .converter_live(converter_live),
  .analog_pin_mask(analog_pin_mask),
  .irq_request(irq_request),
  .wake_pulse(wake_pulse),
  .vector_branch(vector_branch)
);
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sleep_mode = 1'b0;
  logic instr_tick = 1'b0;
  logic rc_tick = 1'b0;
  logic comp_high = 1'b0;
  logic clk_en = 1'b1;
  logic vexp = 1'b0;
  logic pref, nref;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] vin = 10'h000;
  logic [7:0] tcnt = 8'h00;
  logic [31:0] seed = 32'hADC4;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, sample_en, converter_live, irq_request, wake_pulse, vb;
  logic [9:0] sar_trial;
  logic [2:0] channel_sel;
  logic [7:0] analog_pin_mask, ctl;
  logic [15:0] e;
  int bad_count = 0;
  int n_tests = 0;
  int c;
  int dv[8] = '{2, 8, 32, 4, 4, 16, 64, 4};
  logic [7:0] ien[3] = '{8'h40, 8'h40, 8'h00};
  logic [7:0] global_irq_enable[3] = '{8'h40, 8'hC0, 8'h00};
  logic [7:0] ri[6] = '{8'h0B, 8'h0C, 8'h1F, 8'h8C, 8'h91, 8'h9F};
  logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};

  conv_clock_select_sequencer dut
  (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sleep_mode(sleep_mode),
    .instr_tick(instr_tick),
    .rc_tick(rc_tick),
    .comp_high(comp_high),
    .sar_trial(sar_trial),
    .sample_en(sample_en),
    .converter_live(converter_live),
    .channel_sel(channel_sel),
    .pos_reference_select(pref),
    .neg_reference_select(nref),
    .analog_pin_mask(analog_pin_mask),
    .irq_request(irq_request),
    .wake_pulse(wake_pulse),
    .vector_branch(vb)
  );

  // system clock
  always #5 pclk = ~pclk;
  // oscillator and instruction ticks, ideal comparator
  always @(posedge pclk)
  begin
    tcnt <= tcnt + 8'h01;
    rc_tick <= (tcnt[1:0] == 2'h3);
    instr_tick <= (tcnt % 8'h05 == 8'h00);
    comp_high <= (vin >= sar_trial);
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction

  // result pair: right justified when j is set
  function automatic logic [15:0] exp_res(input logic [9:0] v, input logic j);
    exp_res = j ? {6'h00, v} : {v, 6'h00};
  endfunction

  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      bad_count++;
      tally_and_finish;
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, {24'h0, d});
  endtask

  task automatic rchk(input logic [7:0] i, input logic [31:0] exp);
    apb(1'b0, i, 32'h0);
    chk($sformatf("reg %h", i), exp, rdata);
  endtask

  // poll the start bit until it reads zero, or wait for a wake or for converter_live to drop, bounded
  task automatic wait_for(input logic wk);
    c = 0;
    rdata = 32'h0000_0002;
    while (wk ? !(wake_pulse === 1'b1 || converter_live === 1'b0) : rdata[1] !== 1'b0)
    begin
      if (wk)
      begin
        @(posedge pclk);
        c++;
      end
      else
      begin
        apb(1'b0, 8'h1F, 32'h0);
        c += 3;
      end
      if (c > 3000)
      begin
        bad_count++;
        tally_and_finish;
      end
    end
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++)
      rchk(ri[i], {24'h0, rv[i]});
    apb(1'b0, 8'h00, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdata);
    wreg(8'h9F, 8'hFF);
    rchk(8'h9F, 32'h70);
    seed = xs(seed);
    wreg(8'h91, seed[7:0]);
    @(posedge pclk);
    chk("pin mask", {24'h0, seed[7:0]}, {24'h0, analog_pin_mask});
    wreg(8'h8C, 8'h40);
    wreg(8'h0B, 8'h40);
    // every clock code, random input and justification
    for (int i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      vin <= seed[9:0];
      e = exp_res(seed[9:0], seed[10]);
      ctl = {seed[10], seed[15:14], seed[13:11], 2'b01};
      wreg(8'h9F, {1'b0, i[2:0], 4'h0});
      wreg(8'h1F, ctl);
      repeat (8) @(posedge pclk);
      chk("channel", {29'h0, seed[13:11]}, {29'h0, channel_sel});
      chk("refs", {30'h0, seed[15:14]}, {30'h0, nref, pref});
      wreg(8'h1F, ctl | 8'h02);
      wait_for(1'b0);
      chk("cycles", 32'h1, {31'h0, c >= 10 * dv[i] && c <= 12 * dv[i] + 8});
      chk("sample", 32'h1, {31'h0, sample_en});
      rchk(8'h0C, 32'h40);
      chk("irq", 32'h1, {31'h0, irq_request});
      rchk(8'h1F, {24'h0, ctl});
      rchk(8'h1E, {24'h0, e[15:8]});
      rchk(8'h9E, {24'h0, e[7:0]});
      wreg(8'h1E, ~e[15:8]);
      rchk(8'h1E, {24'h0, e[15:8]});
      wreg(8'h0C, 8'h00);
      rchk(8'h0C, 32'h0);
      chk("irq", 32'h0, {31'h0, irq_request});
      repeat (2 * dv[i]) @(posedge pclk);
    end
    // sleep aborts a conversion on a system clock division
    wreg(8'h9F, 8'h60);
    wreg(8'h1F, 8'h83);
    repeat (20) @(posedge pclk);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("live", 32'h0, {31'h0, converter_live});
    rchk(8'h1F, 32'h81);
    sleep_mode <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("live", 32'h1, {31'h0, converter_live});
    rchk(8'h0C, 32'h0);
    // conversions on the internal oscillator across sleep
    for (int m = 0; m < 3; m++)
    begin
      wreg(8'h9F, 8'h30);
      wreg(8'h8C, ien[m]);
      wreg(8'h0B, global_irq_enable[m]);
      wreg(8'h1F, 8'h83);
      sleep_mode <= 1'b1;
      wait_for(1'b1);
      chk("wake", {31'h0, ien[m][6]}, {31'h0, wake_pulse});
      repeat (2) @(posedge pclk);
      if (ien[m][6])
        vexp = global_irq_enable[m][7];
      chk("vector", {31'h0, vexp}, {31'h0, vb});
      rchk(8'h1F, 32'h81);
      sleep_mode <= 1'b0;
      rchk(8'h0C, 32'h40);
      wreg(8'h0C, 8'h00);
    end
    e = exp_res(vin, 1'b1);
    rchk(8'h9E, {24'h0, e[7:0]});
    // clock enable low freezes a conversion, then reset in mid conversion keeps the result pair
    wreg(8'h9F, 8'h00);
    wreg(8'h1F, 8'h83);
    clk_en <= 1'b0;
    repeat (60) @(posedge pclk);
    clk_en <= 1'b1;
    rchk(8'h1F, 32'h83);
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(8'h1F, 32'h0);
    rchk(8'h91, 32'hFF);
    rchk(8'h1E, {24'h0, e[15:8]});
    rchk(8'h9E, {24'h0, e[7:0]});
    tally_and_finish;
  end
endmodule
`default_nettype wire
